// ===== include/bip_defines.svh
`ifndef BIP_DEFINES_SVH
`define BIP_DEFINES_SVH

// local port offsets inside one bank (low nibble of the I/O address)
`define BIP_A_CMD 4'h0
`define BIP_A_DATA 4'h1
`define BIP_A_COMPAT 4'h2
// address bit 3 set selects a vector register, bits 2:0 the input
`define BIP_A_VEC_BIT 3

// command word decode on the command port
`define BIP_FIRST_WORD_BIT 4
`define BIP_READ_POLL_BIT 3
// first initialization word fields
`define BIP_LEVEL_BIT 3
`define BIP_SINGLE_BIT 1
`define BIP_OPTS_BIT 0
// options word fields
`define BIP_AUTO_EOI_BIT 1
`define BIP_SPEC_NEST_BIT 4
// eoi/priority word fields
`define BIP_ROT_BIT 7
`define BIP_SPECIFIC_BIT 6
`define BIP_EOI_BIT 5
// read/poll word fields
`define BIP_SMASK_EN_BIT 6
`define BIP_SMASK_BIT 5
`define BIP_POLL_BIT 2
`define BIP_REG_READ_BIT 1
`define BIP_READ_SVC_BIT 0
// poll answer flag position
`define BIP_POLL_FLAG_BIT 7

// reset values
`define BIP_LOW_PRIO_RST 3'h7
`define BIP_MASK_RST 8'h00
`define BIP_EDGE_RST 8'hff

`endif

// ===== include/bip_pkg.sv
package bip_pkg;

  // initialization sequencing
  typedef enum logic [2:0] {
    BIP_ST_IDLE,
    BIP_ST_W2,
    BIP_ST_W3,
    BIP_ST_W4,
    BIP_ST_RUN
  } bip_init_e;

  // one access on the internal I/O data bus
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bip_io_s;

  typedef logic [7:0][7:0] bip_vec_t;

  // whole state of one bank
  typedef struct packed {
    bip_init_e init_st;
    logic level_mode;
    logic cascade;
    logic need_opts;
    logic auto_eoi;
    logic spec_nest;
    logic [7:0] cascade_map;
    logic [7:0] mask;
    logic [7:0] pend_req;
    logic [7:0] in_svc;
    logic [7:0] prev_act;
    logic [2:0] low_prio;
    logic spec_mask;
    logic read_in_svc;
    logic poll_pend;
    logic rot_auto;
    bip_vec_t vec;
    logic [7:0] compat_val;
    logic compat_req;
    logic [7:0] rdata;
    logic int_req;
    logic ack_valid;
    logic [7:0] ack_vector;
    logic ack_slave;
    logic [2:0] ack_lvl;
  } bip_state_s;

endpackage

// ===== rtl/bip_bank.sv
// Operation
// - first init word picks edge or level sensitive request inputs
// - first init word picks single or cascade; cascade word taken only in cascade
// - options word taken only when the first init word asked for it
// - compat word stored but unused; any bank's write raises level 1.5 request
// - level 1.5 request clears on compat read; software reads all three banks
// - cascade word marks inputs with slaves; used when giving acknowledge vectors
// - options word picks automatic or software eoi and special nested mode
// - after init: fully nested priority, requests accepted; op words write only
// - mask word write loads the mask register directly
// - eoi/priority word level field 0-7 picks eoi bit or priority level
// - eoi/priority word picks eoi kind and rotation mode
// - poll and register read together: poll wins, status gives poll result
// - status read gives poll code, pending requests or in-service bits
// - mask read returns the last written mask bits
// - each input has a vector register driven out on acknowledge
// - first init word resets edge detector; new high-to-low needed
// - first init word clears mask and makes input 7 lowest priority
// - first init word clears special mask, selects request reads, no auto eoi
// - register selection persists for status reads; poll lasts one read
// - status read after poll marks the level in service, keeps its request and returns level
// - request pins are active low and inverted internally
`timescale 1ns/10ps
`include "bip_defines.svh"

module bip_bank
  import bip_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire bip_io_s io,
  output logic [7:0] io_rdata,
  input wire logic [7:0] irq_n,
  input wire logic compat_wr_other,
  input wire logic compat_rd_other,
  output logic compat_req,
  input wire logic ack_req,
  output logic ack_valid,
  output logic [7:0] ack_vector,
  output logic ack_slave,
  output logic int_req
);

  bip_state_s st_reg;
  bip_state_s st_next;

  logic [7:0] act;
  logic [7:0] elig;
  logic [7:0] in_svc_view;
  logic found;
  logic [2:0] lvl;
  logic [2:0] rank_req;
  logic blocked;
  logic grant;
  logic svc_found;
  logic [2:0] svc_hi;
  logic [2:0] lvl_field;

  assign act = ~irq_n;
  assign lvl_field = io.wdata[2:0];

  // priority resolution: rank 0 is the level just after the lowest one
  always_comb begin
    logic [2:0] idx;
    idx = 3'h0;
    found = 1'b0;
    lvl = 3'h0;
    rank_req = 3'h7;
    blocked = 1'b0;
    svc_found = 1'b0;
    svc_hi = 3'h0;
    elig = st_reg.pend_req & ~st_reg.mask;
    // special mask lets masked in-service levels stop inhibiting
    in_svc_view = st_reg.spec_mask ? (st_reg.in_svc & ~st_reg.mask) : st_reg.in_svc;
    for (int i = 0; i < 8; i++) begin
      idx = 3'(st_reg.low_prio + 3'(i) + 3'h1);
      if (!found && elig[idx]) begin
        found = 1'b1;
        lvl = idx;
        rank_req = 3'(i);
      end
      if (!svc_found && st_reg.in_svc[idx]) begin
        svc_found = 1'b1;
        svc_hi = idx;
      end
    end
    // fully nested: equal or higher level in service blocks
    for (int i = 0; i < 8; i++) begin
      idx = 3'(st_reg.low_prio + 3'(i) + 3'h1);
      if (in_svc_view[idx] && (3'(i) < rank_req
          || (3'(i) == rank_req && !st_reg.spec_nest))) begin
        blocked = 1'b1;
      end
    end
    grant = found && !blocked && (st_reg.init_st == BIP_ST_RUN);
  end

  // next state: inputs first, then acknowledge, then bus reads and writes
  always_comb begin
    st_next = st_reg;
    st_next.ack_valid = 1'b0;
    st_next.prev_act = act;
    // edge or level capture of requests
    for (int i = 0; i < 8; i++) begin
      if (st_reg.level_mode) begin
        st_next.pend_req[i] = act[i];
      end else if (act[i] && !st_reg.prev_act[i]) begin
        st_next.pend_req[i] = 1'b1;
      end
    end
    st_next.int_req = grant;

    // acknowledge cycle drives the vector of the granted input
    if (ack_req && grant) begin
      st_next.ack_valid = 1'b1;
      st_next.ack_lvl = lvl;
      st_next.ack_vector = st_reg.vec[lvl];
      // slave marking steers who supplies the vector
      st_next.ack_slave = st_reg.cascade && st_reg.cascade_map[lvl];
      st_next.in_svc[lvl] = !st_reg.auto_eoi;
      if (!st_reg.level_mode) begin
        st_next.pend_req[lvl] = 1'b0;
      end
      if (st_reg.auto_eoi && st_reg.rot_auto) begin
        st_next.low_prio = lvl;
      end
    end

    // any compat read clears the shared level 1.5 request
    if (compat_rd_other) begin
      st_next.compat_req = 1'b0;
    end

    if (io.rd) begin
      if (io.addr[`BIP_A_VEC_BIT]) begin
        st_next.rdata = st_reg.vec[io.addr[2:0]];
      end else begin
        case (io.addr)
          `BIP_A_CMD: begin
            if (st_reg.poll_pend) begin
              st_next.rdata = {grant, 4'h0, lvl};
              if (grant) begin
                st_next.in_svc[lvl] = 1'b1;
              end
              st_next.poll_pend = 1'b0;
            end else begin
              st_next.rdata = st_reg.read_in_svc ? st_reg.in_svc : st_reg.pend_req;
            end
          end
          `BIP_A_DATA: st_next.rdata = st_reg.mask;
          `BIP_A_COMPAT: begin
            st_next.rdata = st_reg.compat_val;
            // local compat read clears the request
            st_next.compat_req = 1'b0;
          end
          default: st_next.rdata = 8'h00;
        endcase
      end
    end

    // set wins over clear, so this follows the clears above
    if (compat_wr_other) begin
      // other bank wrote its compat word
      st_next.compat_req = 1'b1;
    end

    if (io.wr) begin
      if (io.addr[`BIP_A_VEC_BIT]) begin
        st_next.vec[io.addr[2:0]] = io.wdata;
      end else begin
        case (io.addr)
          `BIP_A_CMD: begin
            if (io.wdata[`BIP_FIRST_WORD_BIT]) begin
              st_next.init_st = BIP_ST_W2;
              st_next.level_mode = io.wdata[`BIP_LEVEL_BIT];
              st_next.cascade = !io.wdata[`BIP_SINGLE_BIT];
              st_next.need_opts = io.wdata[`BIP_OPTS_BIT];
              st_next.prev_act = `BIP_EDGE_RST;
              st_next.pend_req = 8'h00;
              st_next.in_svc = 8'h00;
              st_next.mask = `BIP_MASK_RST;
              st_next.low_prio = `BIP_LOW_PRIO_RST;
              // normal mask, request reads, no auto eoi
              st_next.spec_mask = 1'b0;
              st_next.read_in_svc = 1'b0;
              st_next.auto_eoi = 1'b0;
              st_next.spec_nest = 1'b0;
              st_next.poll_pend = 1'b0;
              st_next.rot_auto = 1'b0;
              st_next.cascade_map = 8'h00;
            end else if (io.wdata[`BIP_READ_POLL_BIT]) begin
              if (io.wdata[`BIP_POLL_BIT]) begin
                st_next.poll_pend = 1'b1;
              end else if (io.wdata[`BIP_REG_READ_BIT]) begin
                st_next.read_in_svc = io.wdata[`BIP_READ_SVC_BIT];
              end
              if (io.wdata[`BIP_SMASK_EN_BIT]) begin
                st_next.spec_mask = io.wdata[`BIP_SMASK_BIT];
              end
            end else begin
              case (io.wdata[7:5])
                3'b001: if (svc_found) st_next.in_svc[svc_hi] = 1'b0;
                3'b101: begin
                  if (svc_found) begin
                    st_next.in_svc[svc_hi] = 1'b0;
                    st_next.low_prio = svc_hi;
                  end
                end
                3'b011: st_next.in_svc[lvl_field] = 1'b0;
                3'b111: begin
                  st_next.in_svc[lvl_field] = 1'b0;
                  st_next.low_prio = lvl_field;
                end
                3'b110: st_next.low_prio = lvl_field;
                3'b100: st_next.rot_auto = 1'b1;
                3'b000: st_next.rot_auto = 1'b0;
                default: st_next.rot_auto = st_reg.rot_auto;
              endcase
            end
          end
          `BIP_A_DATA: begin
            case (st_reg.init_st)
              BIP_ST_W2: begin
                st_next.compat_val = io.wdata;
                st_next.compat_req = 1'b1;
                if (st_reg.cascade) begin
                  st_next.init_st = BIP_ST_W3;
                end else if (st_reg.need_opts) begin
                  st_next.init_st = BIP_ST_W4;
                end else begin
                  st_next.init_st = BIP_ST_RUN;
                end
              end
              BIP_ST_W3: begin
                st_next.cascade_map = io.wdata;
                st_next.init_st = st_reg.need_opts ? BIP_ST_W4 : BIP_ST_RUN;
              end
              BIP_ST_W4: begin
                st_next.auto_eoi = io.wdata[`BIP_AUTO_EOI_BIT];
                st_next.spec_nest = io.wdata[`BIP_SPEC_NEST_BIT];
                st_next.init_st = BIP_ST_RUN;
              end
              default: st_next.mask = io.wdata;
            endcase
          end
          default: st_next.rdata = st_next.rdata;
        endcase
      end
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.init_st <= BIP_ST_IDLE;
      st_reg.low_prio <= `BIP_LOW_PRIO_RST;
      st_reg.prev_act <= `BIP_EDGE_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign io_rdata = st_reg.rdata;
  assign compat_req = st_reg.compat_req;
  assign ack_valid = st_reg.ack_valid;
  assign ack_vector = st_reg.ack_vector;
  assign ack_slave = st_reg.ack_slave;
  assign int_req = st_reg.int_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence first_word_s;
    ce && io.wr && io.addr == `BIP_A_CMD && io.wdata[`BIP_FIRST_WORD_BIT];
  endsequence
  sequence compat_step_s;
    ce && io.wr && io.addr == `BIP_A_DATA && st_reg.init_st == BIP_ST_W2;
  endsequence
  sequence poll_cmd_s;
    ce && io.wr && io.addr == `BIP_A_CMD && !io.wdata[`BIP_FIRST_WORD_BIT]
      && io.wdata[`BIP_READ_POLL_BIT] && io.wdata[`BIP_POLL_BIT];
  endsequence
  sequence status_read_s;
    ce && io.rd && io.addr == `BIP_A_CMD;
  endsequence

  restart_seq_a: assert property (first_word_s |=> st_reg.init_st == BIP_ST_W2)
    else $error("first init word did not restart sequencing");
  clear_mask_a: assert property (first_word_s |=> st_reg.mask == 8'h00
      && st_reg.low_prio == 3'h7)
    else $error("first init word did not clear mask or priority");
  skip_cascade_a: assert property (compat_step_s and !st_reg.cascade
      |=> st_reg.init_st != BIP_ST_W3)
    else $error("cascade word accepted in single mode");
  opts_gate_a: assert property (compat_step_s and !st_reg.cascade and !st_reg.need_opts
      |=> st_reg.init_st == BIP_ST_RUN && !st_reg.auto_eoi)
    else $error("options word step taken when not requested");
  mask_load_a: assert property (ce && io.wr && io.addr == `BIP_A_DATA
      && st_reg.init_st == BIP_ST_RUN |=> st_reg.mask == $past(io.wdata))
    else $error("mask word not loaded");
  mask_read_a: assert property (ce && io.rd && io.addr == `BIP_A_DATA && !io.wr
      |=> io_rdata == $past(st_reg.mask))
    else $error("mask readback wrong");
  compat_raise_a: assert property (ce && compat_wr_other |=> compat_req)
    else $error("level 1.5 request not raised");
  poll_once_a: assert property (status_read_s and st_reg.poll_pend and !io.wr
      |=> !st_reg.poll_pend && io_rdata[`BIP_POLL_FLAG_BIT] == $past(grant)
      && io_rdata[2:0] == $past(lvl))
    else $error("poll selection outlived its read");
  poll_wins_a: assert property (poll_cmd_s and io.wdata[`BIP_REG_READ_BIT]
      |=> st_reg.poll_pend)
    else $error("poll did not override register read");
  vec_drive_a: assert property (ack_valid |-> ack_vector == st_reg.vec[st_reg.ack_lvl]
      || $past(ce && io.wr && io.addr[`BIP_A_VEC_BIT]))
    else $error("acknowledge vector mismatch");

endmodule

// ===== sim/bip_host.sv
`timescale 1ns/10ps
`include "bip_defines.svh"

module bip_host
  import bip_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] io_rdata,
  output bip_io_s io
);
  // idle edges after each access beyond the first; raised to act as a slow host
  int gap = 0;

  // bus idle until the first access
  initial io = '0;

  // one write strobe, then idle edges so two strobes never merge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    io.addr = a;
    io.wdata = d;
    io.wr = 1'b1;
    @(posedge clk);
    #1 io.wr = 1'b0;
    repeat (gap + 1) @(posedge clk);
    #1;
  endtask

  // read data is taken only after the answering edge has landed
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    io.addr = a;
    io.rd = 1'b1;
    @(posedge clk);
    #1 io.rd = 1'b0;
    repeat (gap + 1) @(posedge clk);
    #1 d = io_rdata;
  endtask

  task automatic init(input logic [7:0] cmd, input logic [7:0] cas, input logic [7:0] opt);
    wr(`BIP_A_CMD, cmd);
    wr(`BIP_A_DATA, 8'h00);
    if (!cmd[`BIP_SINGLE_BIT]) wr(`BIP_A_DATA, cas);
    if (cmd[`BIP_OPTS_BIT]) wr(`BIP_A_DATA, opt);
  endtask

  // compat readback; only this bank is modelled
  task automatic drop_compat();
    logic [7:0] d;
    rd(`BIP_A_COMPAT, d);
  endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
`include "bip_defines.svh"

module tb
  import bip_pkg::*;
();
  logic clk, reset, ce, compat_wr_other, compat_rd_other, ack_req;
  logic [7:0] irq_n, io_rdata, ack_vector, d;
  logic compat_req, ack_valid, ack_slave, int_req;
  bip_io_s io;
  int fail_count = 0;
  int checks_done = 0;

  // bank under test and the host that programs it
  bip_bank uut (.clk(clk), .reset(reset), .ce(ce), .io(io), .io_rdata(io_rdata),
    .irq_n(irq_n), .compat_wr_other(compat_wr_other), .compat_rd_other(compat_rd_other),
    .compat_req(compat_req), .ack_req(ack_req), .ack_valid(ack_valid),
    .ack_vector(ack_vector), .ack_slave(ack_slave), .int_req(int_req));
  bip_host host (.clk(clk), .io_rdata(io_rdata), .io(io));

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one acknowledge pulse; the answer stands only in the next cycle
  task automatic ack(input logic [7:0] vec, input logic slv);
    ack_req = 1'b1;
    @(posedge clk);
    #1 ack_req = 1'b0;
    chk({7'h00, ack_valid}, 8'h01, "ack pulse");
    chk(ack_vector, vec, "ack vector");
    chk({7'h00, ack_slave}, {7'h00, slv}, "ack slave");
  endtask

  task t_init_single();
    irq_n = 8'hfe;
    host.wr(4'ha, 8'h42);
    host.rd(4'ha, d);
    chk(d, 8'h42, "vector rw");
    host.init(8'h12, 8'h00, 8'h00);
    chk({7'h00, compat_req}, 8'h01, "compat req");
    host.drop_compat();
    chk({7'h00, compat_req}, 8'h00, "compat clear");
    host.rd(`BIP_A_DATA, d);
    chk(d, 8'h00, "mask cleared");
    host.wr(`BIP_A_DATA, 8'h55);
    host.wr(4'h3, 8'hff);
    host.rd(`BIP_A_DATA, d);
    chk(d, 8'h55, "mask readback");
    host.wr(`BIP_A_DATA, 8'h00);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h00, "no stale edge");
    $display("test init_single done");
  endtask

  task t_edge_ack();
    irq_n[2] = 1'b0;
    step(3);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h04, "request bit");
    chk({7'h00, int_req}, 8'h01, "int req");
    ack(8'h42, 1'b0);
    host.wr(`BIP_A_CMD, 8'h0b);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h04, "in service");
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h04, "selection kept");
    host.wr(`BIP_A_CMD, 8'h63);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h04, "wrong level eoi");
    host.wr(`BIP_A_CMD, 8'h62);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h00, "specific eoi");
    irq_n[2] = 1'b1;
    step(2);
    irq_n[2] = 1'b0;
    step(3);
    ack(8'h42, 1'b0);
    host.wr(`BIP_A_CMD, 8'h20);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h00, "nonspecific eoi");
    $display("test edge_ack done");
  endtask

  task t_poll();
    host.gap = 2;
    irq_n[5] = 1'b0;
    step(3);
    host.wr(`BIP_A_CMD, 8'h0e);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h85, "poll answer");
    host.wr(`BIP_A_CMD, 8'h0b);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h20, "poll sets service");
    host.wr(`BIP_A_CMD, 8'h20);
    host.gap = 0;
    $display("test poll done");
  endtask

  task t_cascade();
    irq_n = 8'hff;
    step(2);
    host.init(8'h11, 8'h04, 8'h02);
    host.drop_compat();
    host.rd(`BIP_A_DATA, d);
    chk(d, 8'h00, "cascade and options taken");
    ce = 1'b0;
    host.wr(`BIP_A_DATA, 8'hff);
    ce = 1'b1;
    host.rd(`BIP_A_DATA, d);
    chk(d, 8'h00, "frozen write");
    irq_n[2] = 1'b0;
    step(3);
    host.wr(`BIP_A_CMD, 8'h80);
    ack(8'h42, 1'b1);
    host.wr(`BIP_A_CMD, 8'h0b);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h00, "auto eoi");
    // acknowledged input 2 became lowest, so 3 now beats 1
    irq_n[1] = 1'b0;
    irq_n[3] = 1'b0;
    step(3);
    host.wr(`BIP_A_CMD, 8'h0c);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h83, "rotate on auto eoi");
    host.wr(`BIP_A_CMD, 8'h20);
    compat_wr_other = 1'b1;
    step(1);
    compat_wr_other = 1'b0;
    step(1);
    chk({7'h00, compat_req}, 8'h01, "other bank write");
    compat_rd_other = 1'b1;
    step(1);
    compat_rd_other = 1'b0;
    step(1);
    chk({7'h00, compat_req}, 8'h00, "other bank read");
    $display("test cascade done");
  endtask

  task t_level();
    irq_n = 8'hf7;
    host.init(8'h1a, 8'h00, 8'h00);
    host.drop_compat();
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h08, "level request");
    irq_n[3] = 1'b1;
    step(3);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h00, "level drop");
    $display("test level done");
  endtask

  // set priority and both rotating eoi commands, seen through polls
  task t_rotate();
    irq_n = 8'hff;
    host.init(8'h12, 8'h00, 8'h00);
    host.drop_compat();
    host.wr(`BIP_A_CMD, 8'hc3);
    irq_n[3] = 1'b0;
    irq_n[4] = 1'b0;
    step(3);
    host.wr(`BIP_A_CMD, 8'h0c);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h84, "set priority");
    host.wr(`BIP_A_CMD, 8'he4);
    host.wr(`BIP_A_CMD, 8'h0c);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h83, "rotate on specific eoi");
    host.wr(`BIP_A_CMD, 8'ha0);
    host.wr(`BIP_A_CMD, 8'h0c);
    host.rd(`BIP_A_CMD, d);
    chk(d, 8'h84, "rotate on nonspecific eoi");
    host.wr(`BIP_A_CMD, 8'h20);
    $display("test rotate done");
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // main sequence; inputs move 1 ns after the rising edge
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    ack_req = 1'b0;
    compat_wr_other = 1'b0;
    compat_rd_other = 1'b0;
    irq_n = 8'hff;
    step(20);
    reset = 1'b0;
    t_init_single();
    t_edge_ack();
    t_poll();
    t_cascade();
    t_level();
    t_rotate();
    end_of_test();
  end

  // the tests need well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
